/* core/pin_function_unit.sv */
// Pin function unit: AXI4-Lite register file and the multiplexing of port A,
// port B between port I/O and peripheral signals, and of the two strobe pins between chip select and column strobe.
// Assumes rst is the power-on reset and all peripherals run on core_clk.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "pfu_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module pin_function_unit #(
  parameter int PORT_PINS = 16,
  parameter int STROBE_PINS = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4*PORT_PINS-1:0] portAFuncOut,
  input wire logic [4*PORT_PINS-1:0] portAFuncOe,
  output logic [4*PORT_PINS-1:0] portAFuncIn,
  input wire logic [PORT_PINS-1:0] portAPinIn,
  output logic [PORT_PINS-1:0] portAPinOut,
  output logic [PORT_PINS-1:0] portAPinOe,
  input wire logic [4*PORT_PINS-1:0] portBFuncOut,
  input wire logic [4*PORT_PINS-1:0] portBFuncOe,
  output logic [4*PORT_PINS-1:0] portBFuncIn,
  input wire logic [PORT_PINS-1:0] portBPinIn,
  output logic [PORT_PINS-1:0] portBPinOut,
  output logic [PORT_PINS-1:0] portBPinOe,
  input wire logic [4*STROBE_PINS-1:0] strobeFuncOut,
  input wire logic [STROBE_PINS-1:0] strobePinIn,
  output logic [STROBE_PINS-1:0] strobePinOut,
  output logic [STROBE_PINS-1:0] strobePinOe
);

  // Register contents; reserved bits are kept at their fixed value.
  logic [15:0] portADirection;
  logic [15:0] portBDirection;
  logic [15:0] portAUpperFunction;
  logic [15:0] portALowerFunction;
  logic [15:0] portBUpperFunction;
  logic [15:0] portBLowerFunction;
  logic [15:0] strobePinSelect;

  pfu_pkg::pfu_state_t state;
  pfu_pkg::pfu_state_t next_state;

  // Address decode on the word index of each channel.
  wire [29:0] wrIndex = s_axi_awaddr[31:2];
  wire [29:0] rdIndex = s_axi_araddr[31:2];
  wire wrPaDir = (wrIndex == `PFU_IDX_PA_DIR);
  wire wrPbDir = (wrIndex == `PFU_IDX_PB_DIR);
  wire wrPaUp = (wrIndex == `PFU_IDX_PA_UPPER);
  wire wrPaLo = (wrIndex == `PFU_IDX_PA_LOWER);
  wire wrPbUp = (wrIndex == `PFU_IDX_PB_UPPER);
  wire wrPbLo = (wrIndex == `PFU_IDX_PB_LOWER);
  wire wrStb = (wrIndex == `PFU_IDX_STROBE);
  wire wrHit = wrPaDir | wrPbDir | wrPaUp | wrPaLo | wrPbUp | wrPbLo |
    wrStb;
  wire rdPaDir = (rdIndex == `PFU_IDX_PA_DIR);
  wire rdPbDir = (rdIndex == `PFU_IDX_PB_DIR);
  wire rdPaUp = (rdIndex == `PFU_IDX_PA_UPPER);
  wire rdPaLo = (rdIndex == `PFU_IDX_PA_LOWER);
  wire rdPbUp = (rdIndex == `PFU_IDX_PB_UPPER);
  wire rdPbLo = (rdIndex == `PFU_IDX_PB_LOWER);
  wire rdStb = (rdIndex == `PFU_IDX_STROBE);
  wire rdHit = rdPaDir | rdPbDir | rdPaUp | rdPaLo | rdPbUp | rdPbLo |
    rdStb;

  // A write lands in the cycle both address and data are taken.
  wire wrFire = (state == pfu_pkg::ST_WR_ACK);

  // Byte lanes 0 and 1 cover the 16-bit registers; lanes 2 and 3 fall on
  // bits that do not exist and are ignored.
  wire [15:0] laneMask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Merge function: keeps unwritten bytes and forces reserved bits.
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [15:0] lanes,
    input logic [15:0] wmask,
    input logic [15:0] fixed
  );
    merge = (((old & ~lanes) | (data & lanes)) & wmask) | fixed;
  endfunction : merge

  wire [15:0] wrData = s_axi_wdata[15:0];

  // Only the power-on reset on rst initialises these; there is no other
  // reset input, so sleep, standby or a manual reset cannot disturb them.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      portADirection <= `PFU_RST_PA_DIR;
      portAUpperFunction <= `PFU_RST_PA_UPPER;
      portALowerFunction <= `PFU_RST_PA_LOWER;
    end else if (wrFire) begin
      if (wrPaDir) begin
        portADirection <= merge(portADirection, wrData, laneMask,
          `PFU_WMASK_ALL, `PFU_FIXED_NONE);
      end
      if (wrPaUp) begin
        portAUpperFunction <= merge(portAUpperFunction, wrData, laneMask,
          `PFU_WMASK_PA_UPPER, `PFU_FIXED_PA_UPPER);
      end
      if (wrPaLo) begin
        portALowerFunction <= merge(portALowerFunction, wrData, laneMask,
          `PFU_WMASK_PA_LOWER, `PFU_FIXED_PA_LOWER);
      end
    end
  end

  // Port B and strobe select registers.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      portBDirection <= `PFU_RST_PB_DIR;
      portBUpperFunction <= `PFU_RST_PB_UPPER;
      portBLowerFunction <= `PFU_RST_PB_LOWER;
      strobePinSelect <= `PFU_RST_STROBE;
    end else if (wrFire) begin
      if (wrPbDir) begin
        portBDirection <= merge(portBDirection, wrData, laneMask,
          `PFU_WMASK_ALL, `PFU_FIXED_NONE);
      end
      if (wrPbUp) begin
        portBUpperFunction <= merge(portBUpperFunction, wrData, laneMask,
          `PFU_WMASK_ALL, `PFU_FIXED_NONE);
      end
      if (wrPbLo) begin
        portBLowerFunction <= merge(portBLowerFunction, wrData, laneMask,
          `PFU_WMASK_ALL, `PFU_FIXED_NONE);
      end
      if (wrStb) begin
        strobePinSelect <= merge(strobePinSelect, wrData, laneMask,
          `PFU_WMASK_STROBE, `PFU_FIXED_STROBE);
      end
    end
  end

  // Read selection; the upper half of the bus word reads as zero.
  wire [15:0] rdValue =
    rdPaDir ? portADirection :
    rdPbDir ? portBDirection :
    rdPaUp ? portAUpperFunction :
    rdPaLo ? portALowerFunction :
    rdPbUp ? portBUpperFunction :
    rdPbLo ? portBLowerFunction :
    rdStb ? strobePinSelect : 16'h0000;

  // Slave sequence: one access at a time, writes before reads when both
  // arrive together. Each ready is a registered one-cycle pulse, which costs
  // a cycle of latency but keeps every bus output on a flip-flop.
  always_comb begin
    next_state = state;
    unique case (state)
      pfu_pkg::ST_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          next_state = pfu_pkg::ST_WR_ACK;
        end else if (s_axi_arvalid) begin
          next_state = pfu_pkg::ST_RD_ACK;
        end
      end
      pfu_pkg::ST_WR_ACK: begin
        next_state = pfu_pkg::ST_WR_RESP;
      end
      pfu_pkg::ST_WR_RESP: begin
        if (s_axi_bready) begin
          next_state = pfu_pkg::ST_IDLE;
        end
      end
      pfu_pkg::ST_RD_ACK: begin
        next_state = pfu_pkg::ST_RD_RESP;
      end
      pfu_pkg::ST_RD_RESP: begin
        if (s_axi_rready) begin
          next_state = pfu_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = pfu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= pfu_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Ready pulses are high exactly during the acknowledge states.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= (next_state == pfu_pkg::ST_WR_ACK);
      s_axi_wready <= (next_state == pfu_pkg::ST_WR_ACK);
      s_axi_arready <= (next_state == pfu_pkg::ST_RD_ACK);
    end
  end

  // Responses; unmapped addresses answer with a slave error.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PFU_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PFU_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `PFU_RESP_OKAY : `PFU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (state == pfu_pkg::ST_RD_ACK) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rdHit ? `PFU_RESP_OKAY : `PFU_RESP_SLVERR;
        s_axi_rdata <= {16'h0000, rdValue};
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Function codes with reserved bits cleared, so single-bit fields give
  // codes 0 and 1 only. No operating-mode input enters the select.
  wire [31:0] portAFields = {
    portAUpperFunction & `PFU_WMASK_PA_UPPER,
    portALowerFunction & `PFU_WMASK_PA_LOWER
  };
  wire [31:0] portBFields = {portBUpperFunction, portBLowerFunction};
  wire [3:0] strobeFields = {
    strobePinSelect[`PFU_STROBE_CS1_LSB +: 2],
    strobePinSelect[`PFU_STROBE_CS3_LSB +: 2]
  };

  // Port A pins. On the write strobe pins, slot 1 carries whichever strobe
  // variant the bus unit has chosen; this block does not decide it.
  for (genvar i = 0; i < PORT_PINS; i++) begin : gen_port_a
    pfu_pin_if pinA ();
    assign pinA.sel = portAFields[2 * i +: 2];
    assign pinA.dirOut = portADirection[i];
    assign pinA.funcOut = portAFuncOut[4 * i +: 4];
    assign pinA.funcOe = portAFuncOe[4 * i +: 4];
    assign pinA.pinIn = portAPinIn[i];
    assign portAFuncIn[4 * i +: 4] = pinA.funcIn;
    assign portAPinOut[i] = pinA.pinOut;
    assign portAPinOe[i] = pinA.pinOe;
    pfu_pin_slice #(
      .KINDS(pfu_pkg::PORT_A_KINDS[12 * i +: 12])
    ) u_slice (
      .core_clk(core_clk),
      .rst(rst),
      .pin(pinA.slice)
    );
  end

  // Port B pins.
  for (genvar i = 0; i < PORT_PINS; i++) begin : gen_port_b
    pfu_pin_if pinB ();
    assign pinB.sel = portBFields[2 * i +: 2];
    assign pinB.dirOut = portBDirection[i];
    assign pinB.funcOut = portBFuncOut[4 * i +: 4];
    assign pinB.funcOe = portBFuncOe[4 * i +: 4];
    assign pinB.pinIn = portBPinIn[i];
    assign portBFuncIn[4 * i +: 4] = pinB.funcIn;
    assign portBPinOut[i] = pinB.pinOut;
    assign portBPinOe[i] = pinB.pinOe;
    pfu_pin_slice #(
      .KINDS(pfu_pkg::PORT_B_KINDS[12 * i +: 12])
    ) u_slice (
      .core_clk(core_clk),
      .rst(rst),
      .pin(pinB.slice)
    );
  end

  // Strobe pins: index 1 is the chip select one pin, index 0 chip select
  // three. Neither has an input function, so their pin input is unused
  // past the synchroniser; it is kept for a uniform pad interface.
  for (genvar i = 0; i < STROBE_PINS; i++) begin : gen_strobe
    pfu_pin_if pinS ();
    assign pinS.sel = strobeFields[2 * i +: 2];
    assign pinS.dirOut = 1'b0;
    assign pinS.funcOut = strobeFuncOut[4 * i +: 4];
    assign pinS.funcOe = 4'h0;
    assign pinS.pinIn = strobePinIn[i];
    assign strobePinOut[i] = pinS.pinOut;
    assign strobePinOe[i] = pinS.pinOe;
    pfu_pin_slice #(
      .KINDS(pfu_pkg::STROBE_KINDS)
    ) u_slice (
      .core_clk(core_clk),
      .rst(rst),
      .pin(pinS.slice)
    );
  end

endmodule : pin_function_unit

`default_nettype wire

/* core/pfu_regs.svh */
// Register indices, reset values and field positions of the pin function unit.
// Assumes inclusion by bare name from any file that needs the register map.
`ifndef PFU_REGS_SVH
`define PFU_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define PFU_IDX_PA_DIR 30'h05ffffc4
`define PFU_IDX_PB_DIR 30'h05ffffc6
`define PFU_IDX_PA_UPPER 30'h05ffffc8
`define PFU_IDX_PA_LOWER 30'h05ffffca
`define PFU_IDX_PB_UPPER 30'h05ffffcc
`define PFU_IDX_PB_LOWER 30'h05ffffce
`define PFU_IDX_STROBE 30'h05ffffee

// Power-on reset values.
`define PFU_RST_PA_DIR 16'h0000
`define PFU_RST_PB_DIR 16'h0000
`define PFU_RST_PA_UPPER 16'h3302
`define PFU_RST_PA_LOWER 16'hff95
`define PFU_RST_PB_UPPER 16'h0000
`define PFU_RST_PB_LOWER 16'h0000
`define PFU_RST_STROBE 16'h5fff

// Writable bits and bits that always read as one.
`define PFU_WMASK_PA_UPPER 16'hfffd
`define PFU_FIXED_PA_UPPER 16'h0002
`define PFU_WMASK_PA_LOWER 16'h55ff
`define PFU_FIXED_PA_LOWER 16'haa00
`define PFU_WMASK_STROBE 16'hf000
`define PFU_FIXED_STROBE 16'h0fff
`define PFU_WMASK_ALL 16'hffff
`define PFU_FIXED_NONE 16'h0000

// Strobe pin select fields, two bits each.
`define PFU_STROBE_CS1_LSB 14
`define PFU_STROBE_CS3_LSB 12

// Bus answers.
`define PFU_RESP_OKAY 2'h0
`define PFU_RESP_SLVERR 2'h2

`endif

/* core/pfu_pkg.sv */
// Types and per-pin function tables of the pin function unit.
// Assumes nothing of its surroundings; every user names items with pfu_pkg::.
package pfu_pkg;

  // What a pin does under one function code.
  typedef enum logic [2:0] {
    KIND_RSV = 3'b000,
    KIND_GPIO = 3'b001,
    KIND_IN = 3'b010,
    KIND_OUT = 3'b011,
    KIND_BIDIR = 3'b100,
    KIND_DIRIO = 3'b101
  } pfu_kind_t;

  // Bus slave states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR_ACK = 3'b001,
    ST_WR_RESP = 3'b010,
    ST_RD_ACK = 3'b011,
    ST_RD_RESP = 3'b100
  } pfu_state_t;

  // Port A, pin 15 first; each pin lists codes 3, 2, 1, 0.
  localparam logic [191:0] PORT_A_KINDS = {
    KIND_IN, KIND_RSV, KIND_IN, KIND_GPIO,
    KIND_OUT, KIND_RSV, KIND_IN, KIND_GPIO,
    KIND_IN, KIND_IN, KIND_IN, KIND_GPIO,
    KIND_OUT, KIND_IN, KIND_IN, KIND_GPIO,
    KIND_RSV, KIND_DIRIO, KIND_BIDIR, KIND_GPIO,
    KIND_RSV, KIND_DIRIO, KIND_BIDIR, KIND_GPIO,
    KIND_OUT, KIND_RSV, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_RSV, KIND_IN, KIND_GPIO,
    KIND_RSV, KIND_RSV, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_RSV, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_RSV, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_RSV, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_IN, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_DIRIO, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_DIRIO, KIND_OUT, KIND_GPIO
  };

  // Port B, pin 15 first; code n selects function slot n.
  localparam logic [191:0] PORT_B_KINDS = {
    KIND_OUT, KIND_RSV, KIND_IN, KIND_GPIO,
    KIND_OUT, KIND_RSV, KIND_IN, KIND_GPIO,
    KIND_OUT, KIND_BIDIR, KIND_IN, KIND_GPIO,
    KIND_OUT, KIND_BIDIR, KIND_IN, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_IN, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_OUT, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_IN, KIND_GPIO,
    KIND_OUT, KIND_OUT, KIND_IN, KIND_GPIO,
    KIND_OUT, KIND_OUT, KIND_IN, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_DIRIO, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_DIRIO, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_DIRIO, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_DIRIO, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_DIRIO, KIND_GPIO,
    KIND_RSV, KIND_OUT, KIND_DIRIO, KIND_GPIO
  };

  // Strobe pins: code 1 chip select, code 2 column strobe.
  localparam logic [11:0] STROBE_KINDS = {
    KIND_RSV, KIND_OUT, KIND_OUT, KIND_RSV
  };

endpackage : pfu_pkg

/* core/pfu_pin_if.sv */
// Signals between the register side of the pin function unit and one pin.
// Assumes one instance per multiplexed pin, all on core_clk.
`timescale 1ns/1ns
`default_nettype none

interface pfu_pin_if;
  logic [1:0] sel;
  logic dirOut;
  logic [3:0] funcOut;
  logic [3:0] funcOe;
  logic [3:0] funcIn;
  logic pinIn;
  logic pinOut;
  logic pinOe;

  modport ctrl (
    output sel, dirOut, funcOut, funcOe, pinIn,
    input funcIn, pinOut, pinOe
  );
  modport slice (
    input sel, dirOut, funcOut, funcOe, pinIn,
    output funcIn, pinOut, pinOe
  );
endinterface : pfu_pin_if

`default_nettype wire

/* core/pfu_pin_slice.sv */
// One multiplexed pin: synchroniser, function select and drive control.
// Assumes pin input from outside the clock domain, selects from registers.
`timescale 1ns/1ns
`default_nettype none

module pfu_pin_slice #(
  parameter logic [11:0] KINDS = 12'h001
) (
  input wire logic core_clk,
  input wire logic rst,
  pfu_pin_if.slice pin
);

  logic syncFirst;
  logic syncSecond;
  pfu_pkg::pfu_kind_t kind;
  logic next_pinOut;
  logic next_pinOe;
  logic [3:0] next_funcIn;

  // The first stage feeds only the second one.
  always_ff @(posedge core_clk) begin
    syncFirst <= pin.pinIn;
    syncSecond <= syncFirst;
  end

  assign kind = pfu_pkg::pfu_kind_t'(KINDS[3 * pin.sel +: 3]);

  // Drive and input routing for the selected function only.
  always_comb begin
    next_pinOut = pin.funcOut[pin.sel];
    next_pinOe = 1'b0;
    next_funcIn = 4'h0;
    unique case (kind)
      pfu_pkg::KIND_GPIO, pfu_pkg::KIND_DIRIO: begin
        next_pinOe = pin.dirOut;
        next_funcIn[pin.sel] = syncSecond;
      end
      pfu_pkg::KIND_IN: begin
        next_funcIn[pin.sel] = syncSecond;
      end
      pfu_pkg::KIND_OUT: begin
        next_pinOe = 1'b1;
      end
      pfu_pkg::KIND_BIDIR: begin
        next_pinOe = pin.funcOe[pin.sel];
        next_funcIn[pin.sel] = syncSecond;
      end
      default: begin
        // Reserved codes leave the pin an undriven input.
        next_pinOut = 1'b0;
      end
    endcase
  end

  // Registered so every pin and peripheral output leaves a flip-flop.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin.pinOut <= 1'b0;
      pin.pinOe <= 1'b0;
      pin.funcIn <= 4'h0;
    end else begin
      pin.pinOut <= next_pinOut;
      pin.pinOe <= next_pinOe;
      pin.funcIn <= next_funcIn;
    end
  end

endmodule : pfu_pin_slice

`default_nettype wire

/* testbench/pfu_checker.sv */
// Concurrent checks on the bus and pin ports of the pin function unit.
// Assumes it is bound to pin_function_unit and sees its ports only.
`timescale 1ns/1ns
`default_nettype none

module pfu_checker #(
  parameter int PORT_PINS = 16,
  parameter int STROBE_PINS = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [PORT_PINS-1:0] portAPinOe,
  input wire logic [STROBE_PINS-1:0] strobePinOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Answers follow the handshake edge by one cycle and wait to be taken.
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  AST_READY_PAIR: assert property (s_axi_awready |-> s_axi_wready
    ##1 !s_axi_awready) else $error("write ready not a pair pulse");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  AST_RD_UPPER: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper read bits set");
  AST_ONE_AT_A_TIME: assert property (s_axi_bvalid
    |-> !s_axi_arready && !s_axi_awready) else $error("overlapped access");
  // Reset values must show as soon as reset is seen, so no disable here.
  AST_RESET_QUIET: assert property (disable iff (1'b0) rst
    |=> !s_axi_bvalid && !s_axi_rvalid && portAPinOe == '0 &&
    strobePinOe == '0) else $error("outputs active in reset");
  AST_STROBE_RESET: assert property ($fell(rst)
    |-> ##[1:2] strobePinOe == '1) else $error("strobe pins not driven");

  CVR_B_STALL: cover property (s_axi_bvalid && !s_axi_bready);
  CVR_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  CVR_RESET: cover property ($fell(rst));
endmodule : pfu_checker

`default_nettype wire

/* testbench/pfu_periph_model.sv */
// Peripherals and pads on the far side of the pin function unit.
// Assumes the bench changes seed to give the peripherals new values.
`timescale 1ns/1ns
`default_nettype none

module pfu_periph_model (
  input wire logic [31:0] seed,
  input wire logic [15:0] aOut,
  input wire logic [15:0] aOe,
  input wire logic [15:0] bOut,
  input wire logic [15:0] bOe,
  output logic [63:0] aFo,
  output logic [63:0] aFoe,
  output logic [63:0] bFo,
  output logic [63:0] bFoe,
  output logic [7:0] sFo,
  output logic [15:0] aPad,
  output logic [15:0] bPad,
  output logic [1:0] sPad
);
  // Port A and B slots get copies of seed, some inverted or half-swapped; bFoe holds seed twice over; sFo XORs two seed bytes.
  assign aFo = {seed, ~seed};
  assign aFoe = {~seed, seed};
  assign bFo = {seed[15:0], seed[31:16], ~seed};
  assign bFoe = {seed, seed};
  assign sFo = seed[7:0] ^ seed[23:16];
  // A port A or B pad follows the block where it drives, else the outside level; sPad is the outside level only.
  assign aPad = (aOe & aOut) | (~aOe & seed[31:16]);
  assign bPad = (bOe & bOut) | (~bOe & seed[15:0]);
  assign sPad = seed[9:8];
endmodule : pfu_periph_model

`default_nettype wire

/* testbench/pin_function_unit_test.sv */
// Self-checking bench of the pin function unit against a register model.
// Assumes the design, the peripheral model and the checker are compiled.
`include "pfu_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module pin_function_unit_test;
  logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, sOut, sOe, sPad;
  logic [63:0] aFo, aFoe, aFi, bFo, bFoe, bFi;
  logic [15:0] aOut, aOe, bOut, bOe, aPad, bPad, rnd;
  logic [7:0] sFo;
  logic [29:0] idx[7] = '{`PFU_IDX_PA_DIR, `PFU_IDX_PB_DIR, `PFU_IDX_PA_UPPER,
    `PFU_IDX_PA_LOWER, `PFU_IDX_PB_UPPER, `PFU_IDX_PB_LOWER, `PFU_IDX_STROBE};
  logic [15:0] rstv[7] = '{16'h0000, 16'h0000, 16'h3302, 16'hff95, 16'h0000,
    16'h0000, 16'h5fff};
  logic [15:0] wm[7] = '{16'hffff, 16'hffff, 16'hfffd, 16'h55ff, 16'hffff,
    16'hffff, 16'hf000};
  logic [15:0] mdl[7];
  int errorCnt, numChecks;

  pin_function_unit i_pin_function_unit (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .portAFuncOut(aFo), .portAFuncOe(aFoe),
    .portAFuncIn(aFi), .portAPinIn(aPad), .portAPinOut(aOut),
    .portAPinOe(aOe), .portBFuncOut(bFo), .portBFuncOe(bFoe),
    .portBFuncIn(bFi), .portBPinIn(bPad), .portBPinOut(bOut),
    .portBPinOe(bOe), .strobeFuncOut(sFo), .strobePinIn(sPad),
    .strobePinOut(sOut), .strobePinOe(sOe));

  pfu_periph_model i_pfu_periph_model (.seed(seed), .aOut(aOut), .aOe(aOe),
    .bOut(bOut), .bOe(bOe), .aFo(aFo), .aFoe(aFoe), .bFo(bFo), .bFoe(bFoe),
    .sFo(sFo), .aPad(aPad), .bPad(bPad), .sPad(sPad));

  // Free-running core clock.
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  // Level each pin should carry when its code c picks slot c.
  function automatic logic [15:0] pick(input logic [63:0] fo,
                                       input logic [31:0] c);
    logic [15:0] p;
    for (int i = 0; i < 16; i++) p[i] = fo[4*i + c[2*i +: 2]];
    return p;
  endfunction : pick

  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    numChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Bus write; the response is held off a cycle to exercise the stall.
  task automatic wr(input int r, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] ln;
    ln = {{8{s[1]}}, {8{s[0]}}};
    awaddr <= (r < 7) ? {idx[r], 2'h0} : 32'h00000004;
    wdata <= {d, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h1;
    @(posedge core_clk);
    chk("bresp", (r < 7) ? `PFU_RESP_OKAY : `PFU_RESP_SLVERR, bresp);
    bready <= 1'h0;
    if (r < 7) mdl[r] = (((mdl[r] & ~ln) | (d & ln)) & wm[r]) |
      (~wm[r] & rstv[r]);
  endtask : wr

  task automatic rd(input int r);
    araddr <= (r < 7) ? {idx[r], 2'h0} : 32'h00000004;
    arvalid <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h1;
    @(posedge core_clk);
    chk("rdata", (r < 7) ? {16'h0000, mdl[r]} : 32'h0, rdata);
    chk("rresp", (r < 7) ? `PFU_RESP_OKAY : `PFU_RESP_SLVERR, rresp);
    rready <= 1'h0;
  endtask : rd

  task automatic rst_check;
    for (int r = 0; r < 7; r++) begin
      mdl[r] = rstv[r];
      rd(r);
    end
    rd(7);
    chk("portAPinOe", 16'h50f7, aOe);
    chk("portAPinOut", pick(aFo, 32'h33005595) & 16'h50f7, aOut & aOe);
    chk("strobePinOe", 2'h3, sOe);
    chk("strobePinOut", {sFo[5], sFo[1]}, sOut);
    $display("test reset values done");
  endtask : rst_check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    rst = 1'h1; awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0;
    arvalid = 1'h0; rready = 1'h0; awaddr = 32'h0; wdata = 32'h0;
    wstrb = 4'h0; araddr = 32'h0; rnd = 16'h4a57; seed = {rnd, lfsr(rnd)};
    errorCnt = 0; numChecks = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    rst_check;
    for (int k = 0; k < 30; k++) begin
      rnd = lfsr(rnd);
      wr(rnd[2:0], lfsr(rnd), rnd[6:3]);
      rd(rnd[2:0]);
    end
    $display("test random access done");
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      seed <= {lfsr(rnd), rnd};
      for (int r = 2; r < 6; r++) wr(r, 16'h0000, 4'h3);
      wr(0, rnd, 4'h3);
      wr(1, ~rnd, 4'h3);
      repeat (5) @(posedge core_clk);
      chk("portAPinOe", rnd, aOe);
      chk("portBPinOe", 16'(~rnd), bOe);
      chk("portAPinOut", pick(aFo, 32'h0) & rnd, aOut & rnd);
      chk("portBPinOut", pick(bFo, 32'h0) & ~rnd, bOut & ~rnd);
      chk("portAFuncIn", aPad, pick(aFi, 32'h0));
      chk("portBFuncIn", bPad, pick(bFi, 32'h0));
      chk("otherFuncIn", 64'h0, (aFi | bFi) & {16{4'he}});
    end
    wr(0, 16'hffff, 4'h3);
    wr(2, 16'h80c0, 4'h3);
    repeat (2) @(posedge core_clk);
    chk("reservedOe", 3'h2, {aOe[15], aOe[14], aOe[11]});
    $display("test port functions done");
    for (int c = 0; c < 4; c++) begin
      wr(6, {c[1:0], c[1:0], 12'h000}, 4'h2);
      repeat (2) @(posedge core_clk);
      chk("strobePinOe", (c == 1 || c == 2) ? 2'h3 : 2'h0, sOe);
      chk("strobePinOut", (c == 1) ? {sFo[5], sFo[1]} :
        (c == 2) ? {sFo[6], sFo[2]} : 2'h0, sOut);
    end
    $display("test strobe select done");
    rst <= 1'h1;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    rst_check;
    tally_and_finish;
  end

  // A hang counts as a mismatch and closes the run.
  initial begin
    repeat (8000) @(posedge core_clk);
    errorCnt++;
    tally_and_finish;
  end
endmodule : pin_function_unit_test

bind pin_function_unit pfu_checker #(.PORT_PINS(PORT_PINS),
  .STROBE_PINS(STROBE_PINS)) i_pfu_checker (.core_clk(core_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .portAPinOe(portAPinOe), .strobePinOe(strobePinOe));

`default_nettype wire
